// ==== hdl/uspc_map.vh ====
// Purpose: Register offsets, field positions and reset values of the port
// Assumes: Included by the serial port design files
// Notes: Definitions only
`ifndef USPC_MAP_VH
`define USPC_MAP_VH
`define USPC_CTRL_ADDR 8'h98
`define USPC_DATA_ADDR 8'h99
`define USPC_CTRL_RESET 8'h40
`define USPC_DATA_RESET 8'h00
`define USPC_BIT_FORMAT 7
`define USPC_BIT_UNUSED 6
`define USPC_BIT_MPFILT 5
`define USPC_BIT_RXEN 4
`define USPC_BIT_TX9 3
`define USPC_BIT_RX9 2
`define USPC_BIT_TXDONE 1
`define USPC_BIT_RXDONE 0
`define USPC_FIFO_DEPTH 32
`endif

// ==== hdl/uspc_fifo.v ====
// Purpose: Transmit byte FIFO with valid/ready on both sides
// Assumes: One clock, synchronous active-low reset
// Notes: Width and depth are parameters; depth must be a power of two
`timescale 1ns/10ps
`default_nettype none
module uspc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire core_clk,
    input wire rst_b,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW:0] wr_ptr_reg;
    reg [AW:0] rd_ptr_reg;
    wire full;
    wire empty;

    // Extra pointer bit tells full from empty
    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
        (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];

    // Pointer and storage update
    always @(posedge core_clk) begin
        if (!rst_b) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    // Storage has no reset, it is only read when valid
    always @(posedge core_clk) begin
        if (in_valid && !full) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/uspc_port.v ====
// Purpose: Serial port control, status and data buffer logic
// Assumes: Byte-wide register bus, timer overflow pulse on core_clk
// Notes: Transmit bytes queue in a FIFO ahead of the shift register
`timescale 1ns/10ps
`default_nettype none
`include "uspc_map.vh"
module uspc_port #(
    parameter FIFO_DEPTH = `USPC_FIFO_DEPTH,
    parameter FIFO_AW = 5
) (
    input wire core_clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output wire tx_ready,
    input wire timer_ovf,
    input wire rx_pin,
    output reg tx_pin,
    output wire serial_irq
);
    localparam TX_IDLE = 2'h0;
    localparam TX_SEND = 2'h1;
    localparam RX_IDLE = 2'h0;
    localparam RX_RECV = 2'h1;

    reg [7:0] ctrl_reg;
    reg [7:0] rx_buf_reg;
    reg rx_s1_reg;
    reg rx_s2_reg;
    reg rx_prev_reg;
    reg tx_tick_reg;
    reg [1:0] tx_state_reg;
    reg [10:0] tx_shift_reg;
    reg [3:0] tx_cnt_reg;
    reg [1:0] rx_state_reg;
    reg rx_half_reg;
    reg [3:0] rx_cnt_reg;
    reg [8:0] rx_shift_reg;
    wire fmt9;
    wire wr_ctrl;
    wire wr_data;
    wire fifo_valid;
    wire fifo_take;
    wire [7:0] fifo_data;
    wire tx_bit_tick;
    wire [3:0] tx_last;
    wire [3:0] rx_last;
    wire tx_done_evt;
    wire rx_stop_evt;
    wire rx_ninth;
    wire rx_accept;
    wire rx_start;

    assign fmt9 = ctrl_reg[`USPC_BIT_FORMAT];
    assign wr_ctrl = reg_wr && (reg_addr == `USPC_CTRL_ADDR);
    assign wr_data = reg_wr && (reg_addr == `USPC_DATA_ADDR);

    // Queue holds up to 32 software writes while a frame is on the line; a write to a full queue is dropped
    uspc_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .in_valid(wr_data),
        .in_ready(tx_ready),
        .in_data(reg_wdata),
        .out_valid(fifo_valid),
        .out_ready(fifo_take),
        .out_data(fifo_data)
    );

    // Receive pin passes two flops before any logic looks at it
    always @(posedge core_clk) begin
        if (!rst_b) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            rx_prev_reg <= 1'b1; // Idle level, so no false edge after reset
        end else begin
            rx_s1_reg <= rx_pin;
            rx_s2_reg <= rx_s1_reg;
            rx_prev_reg <= rx_s2_reg;
        end
    end

    // Transmit bit clock: every second overflow
    always @(posedge core_clk) begin
        if (!rst_b) begin
            tx_tick_reg <= 1'b0;
        end else if (timer_ovf) begin
            tx_tick_reg <= ~tx_tick_reg;
        end
    end
    assign tx_bit_tick = timer_ovf && tx_tick_reg;

    // Frame: start, data LSB first, optional ninth, stop
    assign tx_last = fmt9 ? 4'h9 : 4'h8;
    // Take a byte only on a bit tick so the start bit lasts a full bit
    assign fifo_take = (tx_state_reg == TX_IDLE) && fifo_valid &&
        tx_bit_tick;
    assign tx_done_evt = (tx_state_reg == TX_SEND) && tx_bit_tick &&
        (tx_cnt_reg == tx_last);

    always @(posedge core_clk) begin
        if (!rst_b) begin
            tx_state_reg <= TX_IDLE;
            tx_shift_reg <= 11'h7ff;
            tx_cnt_reg <= 4'h0;
            tx_pin <= 1'b1;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    tx_pin <= 1'b1;
                    if (fifo_valid && tx_bit_tick) begin
                        // Ninth bit used only in 9-bit frames
                        tx_shift_reg <= fmt9 ?
                            {1'b1, ctrl_reg[`USPC_BIT_TX9], fifo_data, 1'b0} :
                            {2'b11, fifo_data, 1'b0};
                        tx_cnt_reg <= 4'h0;
                        tx_state_reg <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    tx_pin <= tx_shift_reg[0];
                    if (tx_bit_tick) begin
                        tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                        tx_cnt_reg <= tx_cnt_reg + 4'h1;
                        if (tx_cnt_reg == tx_last + 4'h1) begin
                            tx_state_reg <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_state_reg <= TX_IDLE;
                end
            endcase
        end
    end

    // Receive: start edge resets the half-rate phase so sampling aligns
    assign rx_last = fmt9 ? 4'ha : 4'h9;
    // Only a falling line starts a frame, so a low stop bit is no start
    assign rx_start = rx_prev_reg && !rx_s2_reg;
    // Stop bit is judged on its own mid-bit sample, not half a bit early
    assign rx_stop_evt = (rx_state_reg == RX_RECV) && timer_ovf &&
        !rx_half_reg && (rx_cnt_reg == rx_last);
    assign rx_ninth = fmt9 ? rx_shift_reg[8] : rx_s2_reg;
    // Filter and overrun check on the stop-bit sample
    assign rx_accept = rx_stop_evt && !ctrl_reg[`USPC_BIT_RXDONE] &&
        (!ctrl_reg[`USPC_BIT_MPFILT] || rx_ninth);

    always @(posedge core_clk) begin
        if (!rst_b) begin
            rx_state_reg <= RX_IDLE;
            rx_half_reg <= 1'b0;
            rx_cnt_reg <= 4'h0;
            rx_shift_reg <= 9'h000;
        end else begin
            case (rx_state_reg)
                RX_IDLE: begin
                    if (ctrl_reg[`USPC_BIT_RXEN] && rx_start) begin
                        rx_half_reg <= 1'b0;
                        rx_cnt_reg <= 4'h0;
                        rx_state_reg <= RX_RECV;
                    end
                end
                RX_RECV: begin
                    if (timer_ovf) begin
                        rx_half_reg <= ~rx_half_reg;
                    end
                    // Sample mid-bit on odd overflows
                    if (timer_ovf && !rx_half_reg) begin
                        rx_cnt_reg <= rx_cnt_reg + 4'h1;
                        if (rx_cnt_reg == 4'h0 && rx_s2_reg) begin
                            rx_state_reg <= RX_IDLE; // False start
                        end else if (rx_cnt_reg != 4'h0 &&
                                     rx_cnt_reg != rx_last) begin
                            rx_shift_reg <= fmt9 ?
                                {rx_s2_reg, rx_shift_reg[8:1]} :
                                {1'b0, rx_s2_reg, rx_shift_reg[7:1]};
                        end
                    end
                    if (rx_stop_evt || !ctrl_reg[`USPC_BIT_RXEN]) begin
                        rx_state_reg <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state_reg <= RX_IDLE;
                end
            endcase
        end
    end

    // Control register; hardware set of a flag wins over software clear
    always @(posedge core_clk) begin
        if (!rst_b) begin
            ctrl_reg <= `USPC_CTRL_RESET;
            rx_buf_reg <= `USPC_DATA_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= (reg_wdata & 8'hbf) | 8'h40;
            end
            if (tx_done_evt) begin
                ctrl_reg[`USPC_BIT_TXDONE] <= 1'b1;
            end
            if (rx_accept) begin
                rx_buf_reg <= rx_shift_reg[7:0];
                ctrl_reg[`USPC_BIT_RX9] <= rx_ninth;
                ctrl_reg[`USPC_BIT_RXDONE] <= 1'b1;
            end
        end
    end

    // Read data registered; unmapped addresses read zero
    always @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == `USPC_CTRL_ADDR) begin
                reg_rdata <= ctrl_reg;
            end else if (reg_addr == `USPC_DATA_ADDR) begin
                reg_rdata <= rx_buf_reg;
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // Flags stay set through interrupt entry; only software clears them
    assign serial_irq = ctrl_reg[`USPC_BIT_TXDONE] |
        ctrl_reg[`USPC_BIT_RXDONE];
endmodule
`default_nettype wire

// ==== dv/uspc_port_chk.sv ====
// Purpose: Port-level checks of the serial port
// Assumes: Bench pulses the timer every fourth clock
// Notes: Bound to uspc_port after the module
`timescale 1ns/10ps
`default_nettype none
module uspc_port_chk (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic tx_ready,
    input wire logic timer_ovf,
    input wire logic rx_pin,
    input wire logic tx_pin,
    input wire logic serial_irq
);
    logic [6:0] idle_reg;
    logic [3:0] sw_reg;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // Quiet-line time; past 100 clocks no frame can still be queued
    always @(posedge core_clk)
        idle_reg <= (!rst_b || !tx_pin) ? 7'h00 :
            (idle_reg == 7'h7f) ? idle_reg : idle_reg + 7'h01;
    // Fields only software changes, mirrored from bus writes
    always @(posedge core_clk)
        if (!rst_b)
            sw_reg <= 4'h0;
        else if (reg_wr && reg_addr == 8'h98)
            sw_reg <= {reg_wdata[7], reg_wdata[5:3]};
    reset_out_a: assert property (
        $rose(rst_b) |-> tx_pin && tx_ready && !serial_irq && reg_rdata == 0)
        else $error("outputs not at reset values");
    rd_hold_a: assert property (
        !reg_rd && !$past(reg_rd) |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    unmap_rd_a: assert property (
        reg_rd && reg_addr[7:1] != 7'h4c |=> ##1 reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    unused_bit_a: assert property (
        reg_rd && reg_addr == 8'h98 |=> ##1 reg_rdata[6])
        else $error("unused control bit not one");
    ctrl_field_a: assert property (
        reg_rd && reg_addr == 8'h98 |=> ##1
        {reg_rdata[7], reg_rdata[5:3]} == $past(sw_reg, 2))
        else $error("control field lost");
    irq_flag_a: assert property (
        reg_rd && reg_addr == 8'h98 && !reg_wr ##1 !reg_wr ##1
        reg_rdata[1:0] != 2'b00 |-> serial_irq)
        else $error("request low with a flag set");
    bit_len_a: assert property (
        $fell(tx_pin) |=> !tx_pin [*5])
        else $error("start bit too short");
    // Start waits for the next bit tick, so up to one bit time passes
    tx_start_a: assert property (
        reg_wr && reg_addr == 8'h99 && idle_reg > 7'h64 |-> ##[3:10] !tx_pin)
        else $error("data write did not start a frame");
    cover property (reg_wr && reg_addr == 8'h99);
    cover property ($rose(serial_irq));
    cover property ($fell(rx_pin));
endmodule
bind uspc_port uspc_port_chk u_chk (.core_clk, .rst_b, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .tx_ready, .timer_ovf, .rx_pin,
    .tx_pin, .serial_irq);
`default_nettype wire

// ==== dv/uspc_remote.sv ====
// Purpose: Remote serial node facing the port
// Assumes: One bit lasts BIT clocks
// Notes: send drives the receive line; got holds the last frame seen
`timescale 1ns/10ps
`default_nettype none
module uspc_remote #(
    parameter int BIT = 8
) (
    input wire logic core_clk,
    input wire logic tx_pin,
    output logic rx_pin
);
    logic [10:0] got;
    // Start, data LSB first, stop; the line rests high after
    task automatic send(input logic [10:0] fr, input int n);
        for (int i = 0; i < n; i++) begin
            #1 rx_pin = fr[i];
            repeat (BIT) @(posedge core_clk);
        end
    endtask
    // Mid-bit sampling of each frame, timed from the start edge
    initial begin
        rx_pin = 1'b1;
        forever begin
            @(negedge tx_pin);
            repeat (BIT / 2) @(posedge core_clk);
            for (int i = 0; i < 11; i++) begin
                got[i] = tx_pin;
                repeat (BIT) @(posedge core_clk);
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/test_uart_serial_port_control.sv ====
// Purpose: Self-checking bench of the serial port
// Assumes: Two overflows make a bit, eight clocks here
// Notes: The remote model owns the receive line
`timescale 1ns/10ps
`default_nettype none
module test_uart_serial_port_control;
    logic core_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic timer_ovf = 1'b0, tx_ready, rx_pin, tx_pin, serial_irq;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [1:0] ovf_cnt = 2'h0;
    int fail_count = 0, check_count = 0;
    uspc_port DUT (.core_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .tx_ready, .timer_ovf, .rx_pin, .tx_pin,
        .serial_irq);
    uspc_remote remote (.core_clk, .tx_pin, .rx_pin);
    // Clock, and an overflow pulse on every fourth edge
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        ovf_cnt <= #1 ovf_cnt + 2'h1;
        timer_ovf <= #1 (ovf_cnt == 2'h3);
    end
    task automatic chk(input string s, input logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge core_clk);
        #1 reg_wr = 1'b0;
    endtask
    // Read after n quiet clocks; data is taken two edges later
    task automatic rdc(input logic [7:0] a, int n, logic [7:0] e, string s);
        repeat (n) @(posedge core_clk);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk);
        #1 reg_rd = 1'b0;
        @(posedge core_clk);
        #1 chk(s, e, reg_rdata);
    endtask
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Reset value, read-only bit 6 and an unmapped place
    task automatic t_regs();
        rdc(8'h98, 0, 8'h40, "ctrl reset");
        rdc(8'h99, 0, 8'h00, "data reset");
        wr(8'h98, 8'h00);
        rdc(8'h98, 0, 8'h40, "bit 6");
        wr(8'h9a, 8'hff);
        rdc(8'h9a, 0, 8'h00, "unmapped");
    endtask
    // Byte out: frame on the line, then done flag and request
    task automatic t_tx(input logic [7:0] c, input logic [10:0] fr);
        wr(8'h98, c);
        // Quiet line first, so the start check in the checker is armed
        repeat (100) @(posedge core_clk);
        wr(8'h99, fr[8:1]);
        rdc(8'h98, 110, c | 8'h42, "tx flag");
        chk("frame", fr[7:0], remote.got[7:0]);
        chk("ninth", {5'h00, fr[10:8]}, {5'h00, remote.got[10:8]});
        chk("request", 8'h01, {7'h00, serial_irq});
        wr(8'h98, c);
    endtask
    // Byte in, a second one dropped while done is up, a zero stop bit
    task automatic t_rx();
        wr(8'h98, 8'h10);
        remote.send({2'b11, 8'h5a, 1'b0}, 10);
        rdc(8'h99, 12, 8'h5a, "rx data");
        rdc(8'h98, 0, 8'h55, "rx flags");
        remote.send({2'b11, 8'h33, 1'b0}, 10);
        rdc(8'h99, 12, 8'h5a, "overrun");
        wr(8'h98, 8'h10);
        rdc(8'h98, 0, 8'h50, "rx clear");
        remote.send({2'b10, 8'h0f, 1'b0}, 11);
        rdc(8'h98, 12, 8'h51, "stop zero");
        wr(8'h98, 8'h00);
    endtask
    // Receiver off, then filtering in both frame formats
    task automatic t_mp();
        remote.send({2'b11, 8'h11, 1'b0}, 10);
        rdc(8'h98, 12, 8'h40, "rx off");
        wr(8'h98, 8'h30);
        remote.send({2'b10, 8'h77, 1'b0}, 11);
        rdc(8'h98, 12, 8'h70, "stop filter");
        wr(8'h98, 8'hb0);
        remote.send({2'b10, 8'h22, 1'b0}, 11);
        rdc(8'h98, 12, 8'hf0, "mp drop");
        remote.send({2'b11, 8'h44, 1'b0}, 11);
        rdc(8'h98, 12, 8'hf5, "mp take");
        rdc(8'h99, 0, 8'h44, "mp data");
    endtask
    // Fill the queue to its depth, then a mid-run reset empties it
    task automatic t_full();
        repeat (33) wr(8'h99, 8'h55);
        chk("full", 8'h00, {7'h00, tx_ready});
        @(posedge core_clk);
        #1 rst_b = 1'b0;
        repeat (12) @(posedge core_clk);
        #1 rst_b = 1'b1;
        chk("ready", 8'h01, {7'h00, tx_ready});
        rdc(8'h98, 0, 8'h40, "ctrl again");
        rdc(8'h99, 0, 8'h00, "data again");
    endtask
    // Reset for 12 clocks, then each scenario in turn
    initial begin
        repeat (12) @(posedge core_clk);
        #1 rst_b = 1'b1;
        t_regs();
        t_tx(8'h08, {2'b11, 8'ha5, 1'b0});
        t_tx(8'h80, {2'b10, 8'h3c, 1'b0});
        t_tx(8'h88, {2'b11, 8'hc3, 1'b0});
        t_rx();
        t_mp();
        t_full();
        print_verdict();
    end
    // Watchdog; the scenarios need under 3000 clocks
    initial begin
        #40000;
        fail_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
